// file: design/iepp_ctrl.sv
/*
  Interrupt enable, four-level priority, pin interrupt flags and stop wake.
  Assumes the CPU core drives a synchronous register port, pulses ack on
  service entry and ret on return; all pins are synchronous to clk_in.
*/
// Functional notes
// - Second-bank enables gate the serial, converter/touch, pin-two, port-one change and timer-three requests.
// - The pin-two enable also enables stop wake, which ignores the global gate.
// - Each priority is a high and low bit pair, 00 lowest to 11 highest.
// - First priority pair: timer two, uart, timer one, pin one, timer zero, pin zero from bit 5 down.
// - Second priority pair: serial, converter/touch, pin two, port-one change, timer three from bit 4 down.
// - Pin zero, pin one, pin two and port-one change all interrupt and can wake from stop.
// - Pins zero and one are low-level triggered with type 0 and falling-edge with type 1.
// - Pin two triggers on a falling edge; port one on any change of a wake-enabled pin.
// - Pin zero and one edge flags set on a falling edge regardless of enable and clear on service entry.
// - The pin-two flag sets on a falling edge regardless of enable and clears on service entry.
// - Writing 0 to a pending-register flag other than low voltage clears it, writing 1 leaves it.
// - The port-one change flag sets on a change of a wake-enabled pin, ignores its enable, clears on entry.
// - A request is served unless equal or higher level is in service; higher preempts lower.
// - Vectors are 0043 port one, 004B pin two, 0053 converter/touch, 005B serial, 003B timer three.
// - Each port-one pin has its own wake enable; a disabled pin is ignored.
`timescale 1ns/1ps
module iepp_ctrl
  import iepp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // Pins
  input wire logic pin_zero_in,
  input wire logic pin_one_in,
  input wire logic pin_two_in,
  input wire logic [7:0] port_one_in,
  // Peripheral events
  input wire logic tmr0_ovf_in,
  input wire logic tmr1_ovf_in,
  input wire logic tmr3_ovf_in,
  input wire logic uart_req_in,
  input wire logic tmr2_req_in,
  input wire logic spi_req_in,
  input wire logic conv_done_in,
  input wire logic touch_done_in,
  input wire logic low_voltage_in,
  // CPU core
  input wire logic irq_ack_in,
  input wire logic irq_ret_in,
  output logic irq_req_out,
  output logic [15:0] irq_vector_out,
  output iepp_pkg::iepp_lvl_t irq_level_out,
  output logic stop_wake_out
);
  import iepp_pkg::*;

  logic [7:0] timer_and_pin_int_control, pending_flags_two, irq_enable_bank_two;
  logic [7:0] irq_enable_bank_one, port_one_pin_wake_en;
  logic [7:0] priority_low_bank_one, priority_high_bank_one;
  logic [7:0] priority_low_bank_two, priority_high_bank_two;
  logic [2:0] pin_prev;
  logic [7:0] port_one_prev;
  logic [3:0] in_service;
  logic [3:0] gnt_idx;
  logic [7:0] next_timer_and_pin_int_control, next_flags, next_en2, next_en1, next_wake;
  logic [7:0] next_pl1, next_ph1, next_pl2, next_ph2, next_rdata;
  logic [3:0] next_in_service, next_gnt_idx;
  logic next_req, next_wake_out;
  logic [15:0] next_vector;
  iepp_lvl_t next_level, top_lvl;
  logic [N_SRC-1:0] req_raw, req_en, en_all;
  logic [N_SRC-1:0][1:0] lvl_all;
  logic pick_valid, eligible, wr_flags;
  logic [3:0] pick_idx;
  iepp_lvl_t pick_lvl;
  logic fall0, fall1, fall2, p1_change, serviced;

  assign fall0 = pin_prev[0] & ~pin_zero_in;
  assign fall1 = pin_prev[1] & ~pin_one_in;
  assign fall2 = pin_prev[2] & ~pin_two_in;
  assign p1_change = |((port_one_in ^ port_one_prev) & port_one_pin_wake_en);
  assign serviced = irq_req_out & irq_ack_in;
  assign wr_flags = sfr_wr_in && sfr_addr_in == A_PEND_FLAGS_TWO;

  // Per-source enable and level, both banks in vector order
  assign en_all = {irq_enable_bank_two[4:0], irq_enable_bank_one[5:0]};
  generate
    for (genvar g = 0; g < N_SRC; g++) begin : g_lvl
      if (g < SRC_TMR3) begin : g_one
        assign lvl_all[g] = {priority_high_bank_one[g], priority_low_bank_one[g]};
      end else begin : g_two
        assign lvl_all[g] = {priority_high_bank_two[g-SRC_TMR3], priority_low_bank_two[g-SRC_TMR3]};
      end
    end
  endgenerate

  always_comb begin
    req_raw = '0;
    req_raw[SRC_PIN0] = timer_and_pin_int_control[TC_TYPE0] ? timer_and_pin_int_control[TC_EDGE0]
                                                            : ~pin_zero_in;
    req_raw[SRC_TMR0] = timer_and_pin_int_control[TC_TF0];
    req_raw[SRC_PIN1] = timer_and_pin_int_control[TC_TYPE1] ? timer_and_pin_int_control[TC_EDGE1]
                                                            : ~pin_one_in;
    req_raw[SRC_TMR1] = timer_and_pin_int_control[TC_TF1];
    req_raw[SRC_UART] = uart_req_in;
    req_raw[SRC_TMR2] = tmr2_req_in;
    req_raw[SRC_TMR3] = pending_flags_two[FL_TF3];
    req_raw[SRC_P1] = pending_flags_two[FL_P1];
    req_raw[SRC_PIN2] = pending_flags_two[FL_PIN2];
    req_raw[SRC_CONV] = pending_flags_two[FL_CONV] | pending_flags_two[FL_TOUCH];
    req_raw[SRC_SPI] = spi_req_in;
    req_en = req_raw & en_all & {N_SRC{irq_enable_bank_one[IE_GATE]}};
  end

  iepp_prio_pick #(.N(N_SRC)) u_pick (
    .req_in(req_en),
    .lvl_in(lvl_all),
    .valid_out(pick_valid),
    .idx_out(pick_idx),
    .lvl_out(pick_lvl)
  );

  always_comb begin
    top_lvl = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (in_service[i]) begin
        top_lvl = 2'(i);
      end
    end
    eligible = pick_valid && (in_service == 4'h0 || pick_lvl > top_lvl);
  end

  // Register writes, hardware flags and service bookkeeping
  always_comb begin
    next_timer_and_pin_int_control = timer_and_pin_int_control;
    next_flags = pending_flags_two;
    next_en1 = irq_enable_bank_one;
    next_en2 = irq_enable_bank_two;
    next_wake = port_one_pin_wake_en;
    next_pl1 = priority_low_bank_one;
    next_ph1 = priority_high_bank_one;
    next_pl2 = priority_low_bank_two;
    next_ph2 = priority_high_bank_two;
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        A_TIMER_PIN_CTRL: next_timer_and_pin_int_control = sfr_wdata_in;
        A_P1_WAKE_EN: next_wake = sfr_wdata_in;
        A_IRQ_EN_ONE: next_en1 = sfr_wdata_in & EN_ONE_MASK;
        A_IRQ_EN_TWO: next_en2 = sfr_wdata_in & BANK_TWO_MASK;
        A_PRIO_LO_ONE: next_pl1 = sfr_wdata_in & BANK_ONE_MASK;
        A_PRIO_HI_ONE: next_ph1 = sfr_wdata_in & BANK_ONE_MASK;
        A_PRIO_LO_TWO: next_pl2 = sfr_wdata_in & BANK_TWO_MASK;
        A_PRIO_HI_TWO: next_ph2 = sfr_wdata_in & BANK_TWO_MASK;
        default: next_timer_and_pin_int_control = timer_and_pin_int_control;
      endcase
    end
    if (wr_flags) begin
      next_flags = pending_flags_two & (sfr_wdata_in | ~FL_RW_MASK);
    end
    // Auto-clear on service entry; level-mode pin requests have no flag to clear
    if (serviced) begin
      case (int'(gnt_idx))
        SRC_PIN0: next_timer_and_pin_int_control[TC_EDGE0] = 1'b0;
        SRC_PIN1: next_timer_and_pin_int_control[TC_EDGE1] = 1'b0;
        SRC_TMR0: next_timer_and_pin_int_control[TC_TF0] = 1'b0;
        SRC_TMR1: next_timer_and_pin_int_control[TC_TF1] = 1'b0;
        SRC_P1: next_flags[FL_P1] = 1'b0;
        SRC_PIN2: next_flags[FL_PIN2] = 1'b0;
        default: next_flags = next_flags;
      endcase
    end
    // Sets come last so an event in the clearing cycle is kept
    next_timer_and_pin_int_control[TC_EDGE0] = next_timer_and_pin_int_control[TC_EDGE0] | fall0;
    next_timer_and_pin_int_control[TC_EDGE1] = next_timer_and_pin_int_control[TC_EDGE1] | fall1;
    next_timer_and_pin_int_control[TC_TF0] = next_timer_and_pin_int_control[TC_TF0] | tmr0_ovf_in;
    next_timer_and_pin_int_control[TC_TF1] = next_timer_and_pin_int_control[TC_TF1] | tmr1_ovf_in;
    next_flags[FL_PIN2] = next_flags[FL_PIN2] | fall2;
    next_flags[FL_P1] = next_flags[FL_P1] | p1_change;
    next_flags[FL_TF3] = next_flags[FL_TF3] | tmr3_ovf_in;
    next_flags[FL_CONV] = next_flags[FL_CONV] | conv_done_in;
    next_flags[FL_TOUCH] = next_flags[FL_TOUCH] | touch_done_in;
    next_flags[FL_LVD] = low_voltage_in;

    next_in_service = in_service;
    if (irq_ret_in && in_service != 4'h0) begin
      next_in_service[top_lvl] = 1'b0;
    end
    if (serviced) begin
      next_in_service[irq_level_out] = 1'b1;
    end
    // Request drops the cycle after the ack so one grant is never taken twice
    next_req = eligible && !serviced;
    next_gnt_idx = pick_idx;
    next_vector = IRQ_VEC[pick_idx];
    next_level = pick_lvl;
    // Stop wake ignores the global gate
    next_wake_out = (irq_enable_bank_one[EN1_PIN0] & ~pin_zero_in) | (irq_enable_bank_one[EN1_PIN1] & ~pin_one_in)
                  | (irq_enable_bank_two[EN2_PIN2] & ~pin_two_in) | p1_change;
  end

  always_comb begin
    case (sfr_addr_in)
      A_TIMER_PIN_CTRL: next_rdata = timer_and_pin_int_control;
      A_PEND_FLAGS_TWO: next_rdata = pending_flags_two;
      A_P1_WAKE_EN: next_rdata = port_one_pin_wake_en;
      A_IRQ_EN_ONE: next_rdata = irq_enable_bank_one;
      A_IRQ_EN_TWO: next_rdata = irq_enable_bank_two;
      A_PRIO_LO_ONE: next_rdata = priority_low_bank_one;
      A_PRIO_HI_ONE: next_rdata = priority_high_bank_one;
      A_PRIO_LO_TWO: next_rdata = priority_low_bank_two;
      A_PRIO_HI_TWO: next_rdata = priority_high_bank_two;
      default: next_rdata = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_and_pin_int_control <= RST_BYTE;
      pending_flags_two <= RST_BYTE;
      irq_enable_bank_one <= RST_BYTE;
      irq_enable_bank_two <= RST_BYTE;
      port_one_pin_wake_en <= RST_BYTE;
      priority_low_bank_one <= RST_BYTE;
      priority_high_bank_one <= RST_BYTE;
      priority_low_bank_two <= RST_BYTE;
      priority_high_bank_two <= RST_BYTE;
      pin_prev <= {3{PIN_IDLE}};
      port_one_prev <= RST_BYTE;
      in_service <= 4'h0;
      gnt_idx <= 4'h0;
      irq_req_out <= 1'b0;
      irq_vector_out <= 16'h0000;
      irq_level_out <= 2'h0;
      stop_wake_out <= 1'b0;
      sfr_rdata_out <= RST_BYTE;
    end else begin
      timer_and_pin_int_control <= next_timer_and_pin_int_control;
      pending_flags_two <= next_flags;
      irq_enable_bank_one <= next_en1;
      irq_enable_bank_two <= next_en2;
      port_one_pin_wake_en <= next_wake;
      priority_low_bank_one <= next_pl1;
      priority_high_bank_one <= next_ph1;
      priority_low_bank_two <= next_pl2;
      priority_high_bank_two <= next_ph2;
      pin_prev <= {pin_two_in, pin_one_in, pin_zero_in};
      port_one_prev <= port_one_in;
      in_service <= next_in_service;
      gnt_idx <= next_gnt_idx;
      irq_req_out <= next_req;
      irq_vector_out <= next_vector;
      irq_level_out <= next_level;
      stop_wake_out <= next_wake_out;
      sfr_rdata_out <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_taken;
    irq_req_out && irq_ack_in;
  endsequence
  sequence s_pin2_fall;
    pin_two_in ##1 !pin_two_in;
  endsequence

  a_pin2_flag_set: assert property (s_pin2_fall |=> pending_flags_two[FL_PIN2])
    else $error("pin two flag missed a falling edge");
  a_pin0_flag_set: assert property ($fell(pin_zero_in) |=> timer_and_pin_int_control[TC_EDGE0])
    else $error("pin zero edge flag missed a falling edge");
  a_flag_write_one: assert property (wr_flags && sfr_wdata_in[FL_PIN2] && pending_flags_two[FL_PIN2]
    && !(serviced && int'(gnt_idx) == SRC_PIN2) |=> pending_flags_two[FL_PIN2])
    else $error("writing one disturbed a flag");
  a_flag_write_zero: assert property (wr_flags && !sfr_wdata_in[FL_P1] && !p1_change
    |=> !pending_flags_two[FL_P1])
    else $error("writing zero did not clear a flag");
  a_p1_masked_pins: assert property (!pending_flags_two[FL_P1] && !serviced
    && ((port_one_in ^ $past(port_one_in)) & port_one_pin_wake_en) == 8'h00 |=> !pending_flags_two[FL_P1])
    else $error("port one flag set without an enabled change");
  a_stop_wake_gate: assert property (irq_enable_bank_two[EN2_PIN2] && !pin_two_in |=> stop_wake_out)
    else $error("pin two low did not raise stop wake");
  a_ack_clear_pin2: assert property (s_taken ##0 (int'(gnt_idx) == SRC_PIN2) && !fall2
    |=> !pending_flags_two[FL_PIN2] ##1 (!irq_req_out || irq_vector_out != IRQ_VEC[SRC_PIN2]))
    else $error("service entry did not clear pin two flag");
  a_single_grant: assert property (s_taken |=> !irq_req_out)
    else $error("request held through its own acknowledge");
  a_no_equal_preempt: assert property (irq_req_out |-> in_service == 4'h0 || irq_level_out > top_lvl)
    else $error("request raised at or below level in service");
  a_gate_blocks: assert property (!irq_enable_bank_one[IE_GATE] ##1 !irq_enable_bank_one[IE_GATE]
    |-> !irq_req_out)
    else $error("request raised with global gate off");
endmodule

// file: design/iepp_pkg.sv
/*
  Shared constants for the interrupt enable, priority and pin interrupt block:
  special-function register addresses, bit positions, masks and vectors.
  Assumes an 8-bit special-function register space addressed by the CPU core.
*/
package iepp_pkg;
  localparam int N_SRC = 11;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic PIN_IDLE = 1'b1;

  // Register addresses
  localparam logic [7:0] A_TIMER_PIN_CTRL = 8'h88;
  localparam logic [7:0] A_PEND_FLAGS_TWO = 8'h95;
  localparam logic [7:0] A_P1_WAKE_EN = 8'h96;
  localparam logic [7:0] A_IRQ_EN_ONE = 8'hA8;
  localparam logic [7:0] A_IRQ_EN_TWO = 8'hA9;
  localparam logic [7:0] A_PRIO_LO_ONE = 8'hB8;
  localparam logic [7:0] A_PRIO_HI_ONE = 8'hB9;
  localparam logic [7:0] A_PRIO_LO_TWO = 8'hBA;
  localparam logic [7:0] A_PRIO_HI_TWO = 8'hBB;

  // Control register bits
  localparam int TC_TYPE0 = 0;
  localparam int TC_EDGE0 = 1;
  localparam int TC_TYPE1 = 2;
  localparam int TC_EDGE1 = 3;
  localparam int TC_TF0 = 5;
  localparam int TC_TF1 = 7;
  // Pending flag and enable register bits
  localparam int FL_TF3 = 0;
  localparam int FL_P1 = 1;
  localparam int FL_PIN2 = 2;
  localparam int FL_CONV = 4;
  localparam int FL_TOUCH = 5;
  localparam int FL_LVD = 7;
  localparam int IE_GATE = 7;
  localparam int EN2_PIN2 = 2;
  localparam int EN1_PIN0 = 0;
  localparam int EN1_PIN1 = 2;

  // Write masks: clearable flag bits, implemented enable and priority bits
  localparam logic [7:0] FL_RW_MASK = 8'h37;
  localparam logic [7:0] EN_ONE_MASK = 8'hBF;
  localparam logic [7:0] BANK_ONE_MASK = 8'h3F;
  localparam logic [7:0] BANK_TWO_MASK = 8'h1F;

  // Source indices, in vector order
  localparam int SRC_PIN0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_PIN1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_UART = 4;
  localparam int SRC_TMR2 = 5;
  localparam int SRC_TMR3 = 6;
  localparam int SRC_P1 = 7;
  localparam int SRC_PIN2 = 8;
  localparam int SRC_CONV = 9;
  localparam int SRC_SPI = 10;

  localparam logic [N_SRC-1:0][15:0] IRQ_VEC = {
    16'h005B, 16'h0053, 16'h004B, 16'h0043, 16'h003B, 16'h002B,
    16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

  typedef logic [1:0] iepp_lvl_t;
endpackage

// file: design/iepp_prio_pick.sv
/*
  Combinational picker: highest level wins, lowest index wins a tie.
  Assumes requests are already gated by enables and indexed in vector order.
*/
`timescale 1ns/1ps
module iepp_prio_pick #(
  parameter int N = 11
) (
  // Requests and their levels
  input wire logic [N-1:0] req_in,
  input wire logic [N-1:0][1:0] lvl_in,
  // Winner
  output logic valid_out,
  output logic [3:0] idx_out,
  output logic [1:0] lvl_out
);
  always_comb begin
    valid_out = 1'b0;
    idx_out = 4'h0;
    lvl_out = 2'h0;
    // Walk downward so an equal level at a lower index replaces the winner
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i] && (!valid_out || lvl_in[i] >= lvl_out)) begin
        valid_out = 1'b1;
        idx_out = 4'(i);
        lvl_out = lvl_in[i];
      end
    end
  end
endmodule

// file: verification/iepp_cpu_model.sv
/*
  Behavioural CPU core model: acknowledges a presented request after a
  programmable wait and records the vector it entered.
  Assumes the block's registered request and vector ports, one clock.
*/
`timescale 1ns/1ps
module iepp_cpu_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Request from the block
  input wire logic irq_req_in,
  input wire logic [15:0] irq_vector_in,
  // Bench control
  input wire logic en_in,
  input wire logic [3:0] delay_in,
  // Service entry
  output logic irq_ack_out,
  output logic [15:0] last_vec_out,
  output int n_ack_out
);
  int cnt;

  // One ack per request; the request drops the cycle after it is taken
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 0;
      irq_ack_out <= 1'b0;
      last_vec_out <= 16'h0000;
      n_ack_out <= 0;
    end else begin
      irq_ack_out <= 1'b0;
      if (en_in && irq_req_in && !irq_ack_out) begin
        if (cnt >= int'(delay_in)) begin
          irq_ack_out <= 1'b1;
          last_vec_out <= irq_vector_in;
          n_ack_out <= n_ack_out + 1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule

// file: verification/iepp_ctrl_tb.sv
/*
  Self-checking bench for the interrupt enable, priority and pin block.
  Assumes the register port timing of the block and the CPU model beside it.
*/
`timescale 1ns/1ps
module iepp_ctrl_tb;
  import iepp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] sfr_rdata_out;
  logic pin_zero_in = 1'b1, pin_one_in = 1'b1, pin_two_in = 1'b1;
  logic [7:0] port_one_in = 8'h00;
  logic tmr3_ovf_in = 1'b0, conv_done_in = 1'b0, spi_req_in = 1'b0, touch_done_in = 1'b0;
  logic low_voltage_in = 1'b0, irq_ret_in = 1'b0, irq_ack_in, ack_en = 1'b1;
  logic [3:0] ack_delay = 4'h0;
  logic irq_req_out, stop_wake_out;
  logic [15:0] irq_vector_out, last_vec;
  iepp_lvl_t irq_level_out;
  int n_ack;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] tbl [8][3] = '{'{8'hA9, 8'hFF, 8'h1F}, '{8'hB8, 8'hFF, 8'h3F}, '{8'hB9, 8'hFF, 8'h3F},
    '{8'hBA, 8'hFF, 8'h1F}, '{8'hBB, 8'hFF, 8'h1F}, '{8'h96, 8'hFF, 8'hFF}, '{8'h88, 8'hFF, 8'hFF},
    '{8'h90, 8'hFF, 8'h00}};

  always #2.5 clk_in = ~clk_in;

  iepp_ctrl uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .pin_zero_in(pin_zero_in),
    .pin_one_in(pin_one_in), .pin_two_in(pin_two_in), .port_one_in(port_one_in), .tmr0_ovf_in(1'b0),
    .tmr1_ovf_in(1'b0), .tmr3_ovf_in(tmr3_ovf_in), .uart_req_in(1'b0), .tmr2_req_in(1'b0),
    .spi_req_in(spi_req_in), .conv_done_in(conv_done_in), .touch_done_in(touch_done_in),
    .low_voltage_in(low_voltage_in), .irq_ack_in(irq_ack_in), .irq_ret_in(irq_ret_in),
    .irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out), .irq_level_out(irq_level_out),
    .stop_wake_out(stop_wake_out));

  iepp_cpu_model cpu (.clk_in(clk_in), .rst_b_in(rst_b_in), .irq_req_in(irq_req_out),
    .irq_vector_in(irq_vector_out), .en_in(ack_en), .delay_in(ack_delay), .irq_ack_out(irq_ack_in),
    .last_vec_out(last_vec), .n_ack_out(n_ack));

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wr_in <= 1'b1;
    sfr_wdata_in <= d;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    sfr_addr_in <= a;
    @(posedge clk_in);
    #1 chk($sformatf("sfr_rdata at %h", a), {8'h00, exp}, {8'h00, sfr_rdata_out});
  endtask

  task automatic pulse_ret();
    @(posedge clk_in);
    irq_ret_in <= 1'b1;
    @(posedge clk_in);
    irq_ret_in <= 1'b0;
  endtask

  // Bounded wait for the model's next service entry
  task automatic wait_ack(input logic [15:0] exp);
    int n0;
    n0 = n_ack;
    for (int i = 0; i < 40 && n_ack == n0; i++) @(posedge clk_in);
    #1 chk("entered vector", exp, (n_ack == n0) ? 16'hxxxx : last_vec);
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(8'h95, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(tbl[i][0], 8'h00);
      wr(tbl[i][0], tbl[i][1]);
      rd(tbl[i][0], tbl[i][2]);
      wr(tbl[i][0], 8'h00);
    end
    $display("test registers done");

    low_voltage_in <= 1'b1;
    wr(8'h96, 8'h01);
    @(posedge clk_in);
    {pin_zero_in, pin_one_in, pin_two_in} <= 3'b000;
    port_one_in <= 8'h03;
    @(posedge clk_in);
    {pin_zero_in, pin_one_in, pin_two_in} <= 3'b111;
    rd(8'h95, 8'h86);
    rd(8'h88, 8'h0A);
    wr(8'h95, 8'hFF);
    rd(8'h95, 8'h86);
    wr(8'h95, 8'hFB);
    rd(8'h95, 8'h82);
    wr(8'h95, 8'hFD);
    rd(8'h95, 8'h80);
    // Only a masked pin changes here
    port_one_in <= 8'h01;
    rd(8'h95, 8'h80);
    low_voltage_in <= 1'b0;
    wr(8'h88, 8'h00);
    $display("test flags done");

    // Gate still off: wake only
    wr(8'hA9, 8'h04);
    @(posedge clk_in);
    pin_two_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk("stop_wake_out", 16'h0001, {15'h0000, stop_wake_out});
    chk("irq_req_out", 16'h0000, {15'h0000, irq_req_out});
    pin_two_in <= 1'b1;
    wr(8'h95, 8'hFB);
    wr(8'hA8, 8'h80);
    @(posedge clk_in);
    pin_two_in <= 1'b0;
    @(posedge clk_in);
    pin_two_in <= 1'b1;
    wait_ack(16'h004B);
    rd(8'h95, 8'h00);
    pulse_ret();
    wr(8'hA9, 8'h02);
    @(posedge clk_in);
    port_one_in <= 8'h02;
    wait_ack(16'h0043);
    rd(8'h95, 8'h00);
    pulse_ret();
    $display("test pin two and port one done");

    ack_en <= 1'b0;
    wr(8'hA8, 8'h81);
    wr(8'hB9, 8'h01);
    @(posedge clk_in);
    pin_zero_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 chk("irq_vector_out", 16'h0003, irq_vector_out);
    chk("irq_req_out", 16'h0001, {15'h0000, irq_req_out});
    chk("irq_level_out", 16'h0002, {14'h0000, irq_level_out});
    pin_zero_in <= 1'b1;
    wr(8'h88, 8'h00);
    repeat (2) @(posedge clk_in);
    #1 chk("irq_req_out", 16'h0000, {15'h0000, irq_req_out});
    ack_en <= 1'b1;
    wr(8'hA8, 8'h84);
    wr(8'h88, 8'h04);
    @(posedge clk_in);
    pin_one_in <= 1'b0;
    @(posedge clk_in);
    pin_one_in <= 1'b1;
    wait_ack(16'h0013);
    rd(8'h88, 8'h04);
    pulse_ret();
    $display("test trigger types done");

    // Slow CPU so the tie is visible before entry
    ack_delay <= 4'h3;
    wr(8'hA8, 8'h80);
    wr(8'hA9, 8'h1F);
    @(posedge clk_in);
    tmr3_ovf_in <= 1'b1;
    conv_done_in <= 1'b1;
    touch_done_in <= 1'b1;
    @(posedge clk_in);
    tmr3_ovf_in <= 1'b0;
    conv_done_in <= 1'b0;
    touch_done_in <= 1'b0;
    wait_ack(16'h003B);
    wr(8'hBA, 8'h08);
    wait_ack(16'h0053);
    rd(8'h95, 8'h31);
    wr(8'h95, 8'hCE);
    spi_req_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    #1 chk("irq_req_out", 16'h0000, {15'h0000, irq_req_out});
    pulse_ret();
    pulse_ret();
    wait_ack(16'h005B);
    spi_req_in <= 1'b0;
    pulse_ret();
    $display("test priority done");
    final_report();
  end
endmodule
